// ### design/mmp_pkg.sv
// Purpose: constants and types for the MII MAC-side port
// Assumes: 250 MHz system clock, APB register access
// Notes: byte addresses, field positions and timing counts live here
// Summary of operation
// - management access is 32 bit times, 192 when multi mode with register 11111
// - two bits after start select read or write
// - then 5-bit device address and 5-bit register address
// - two turnaround bit times after register address for direction change
// - final part carries 16 data bits, or 176 in multi mode
// - transmission starts with enable high and first preamble nibble together
// - transmit nibble LSB on bit 0, MSB on bit 3
// - transmit enable and data change on transmit clock rising edges
// - transmit enable drops on the transmit clock rising edge after the last FCS nibble
// - collision input is synchronised before use
// - receive valid rises with preamble; one flag octet of training suffices
// - receive valid and data sampled on receive clock rising edges
// - receive error anywhere in a packet sets the bad flag at its end; its bytes are still delivered
// - opening flag found by 5Dh at nibble alignment; other patterns tolerated
// - carrier only gates deferral, never receive framing
// - internal PHY isolated from reset until disable bit cleared; external select 0
// - management clock high and low at least 160 ns, period at least 400 ns
// - management idle after 32 ones; new access only after that
package mmp_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_CONFIG    = 8'h00;
	localparam logic [7:0] ADDR_STATUS    = 8'h04;
	localparam logic [7:0] ADDR_TX_DATA   = 8'h08;
	localparam logic [7:0] ADDR_RX_DATA   = 8'h0C;
	localparam logic [7:0] ADDR_MGMT_CMD  = 8'h10;
	localparam logic [7:0] ADDR_MGMT_DATA = 8'h14;
	localparam logic [7:0] ADDR_MGMT_IDX  = 8'h18;
	// config fields
	localparam int CFG_EXTERNAL_PHY_SELECT_BIT_BIT   = 0;
	localparam int CFG_MEDIA_DIS_BIT = 1;
	localparam int CFG_FULL_DUP_BIT  = 2;
	localparam logic CFG_EXTERNAL_PHY_SELECT_BIT_RST   = 1'b0;
	localparam logic CFG_MEDIA_DIS_RST = 1'b1;
	localparam logic CFG_FULL_DUP_RST  = 1'b0;
	// status fields
	localparam int ST_TX_BUSY   = 0;
	localparam int ST_TX_EMPTY  = 1;
	localparam int ST_RX_VALID  = 2;
	localparam int ST_RX_DONE   = 3;
	localparam int ST_RX_BAD    = 4;
	localparam int ST_COLL      = 5;
	localparam int ST_CARRIER   = 6;
	localparam int ST_MGMT_BUSY = 7;
	localparam int ST_RX_OVER   = 8;
	localparam int ST_TX_UNDER  = 9;
	// data and command fields
	localparam int DATA_LAST_BIT = 8;
	localparam int CMD_OP_LSB    = 0;
	localparam int CMD_PHY_LSB   = 2;
	localparam int CMD_REG_LSB   = 7;
	localparam int CMD_MULTI_BIT = 12;
	localparam int CMD_GO_BIT    = 31;
	// management frame
	localparam logic [1:0] MGMT_OP_READ  = 2'b10;
	localparam logic [1:0] MGMT_OP_WRITE = 2'b01;
	localparam logic [1:0] MGMT_START    = 2'b01;
	localparam logic [4:0] MGMT_REG_ALL  = 5'h1F;
	localparam int MGMT_IDLE_BITS   = 32;
	localparam int MGMT_HDR_BITS    = 16;
	localparam int MGMT_ADDR_BITS   = 14;
	localparam int MGMT_WORD_BITS   = 16;
	localparam int MGMT_WORDS       = 11;
	localparam int MGMT_SINGLE_BITS = 32;
	localparam int MGMT_MULTI_BITS  = 192;
	// management clock timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int MDC_HALF_MIN_NS = 160;
	localparam int MDC_PERIOD_MIN_NS = 400;
	localparam int MDC_HALF_A = (MDC_HALF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MDC_HALF_B = (MDC_PERIOD_MIN_NS + 2 * CLK_PERIOD_NS - 1)
		/ (2 * CLK_PERIOD_NS);
	localparam int MDC_HALF_CYC = (MDC_HALF_A > MDC_HALF_B) ? MDC_HALF_A : MDC_HALF_B;
	// nibble patterns
	localparam logic [3:0] NIB_PREAMBLE = 4'h5;
	localparam logic [3:0] NIB_SFD      = 4'hD;
	localparam logic [3:0] PRE_NIBBLES  = 4'hF;

	typedef enum logic [3:0] {
		TX_IDLE = 4'b0001,
		TX_PRE  = 4'b0010,
		TX_LO   = 4'b0100,
		TX_HI   = 4'b1000
	} mmp_tx_state_type;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b001,
		RX_HUNT = 3'b010,
		RX_DATA = 3'b100
	} mmp_rx_state_type;

	typedef enum logic [1:0] {
		MG_IDLE = 2'b01,
		MG_RUN  = 2'b10
	} mmp_mg_state_type;
endpackage : mmp_pkg

// ### design/mmp_mgmt_if.sv
// Purpose: command and data path between register file and management engine
// Assumes: single clock domain
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface mmp_mgmt_if;
	logic        start;
	logic [1:0]  op;
	logic [4:0]  phy_addr;
	logic [4:0]  reg_select_field;
	logic        multi_en;
	logic        busy;
	logic        done;
	logic [3:0]  idx;
	logic        wr_en;
	logic [15:0] wdata;
	logic [15:0] rdata;

	modport regs (output start, op, phy_addr, reg_select_field, multi_en, idx, wr_en,
		wdata, input busy, done, rdata);
	modport engine (input start, op, phy_addr, reg_select_field, multi_en, idx, wr_en,
		wdata, output busy, done, rdata);
endinterface : mmp_mgmt_if
`default_nettype wire

// ### design/mmp_mgmt_serial.sv
// Purpose: management serial frame engine, sources the management clock
// Assumes: management data pin input is asynchronous
// Notes: every access is preceded by 32 ones so the far end sees idle
`timescale 1ns/1ps
`default_nettype none
module mmp_mgmt_serial #(
	parameter int HALF_CYC = mmp_pkg::MDC_HALF_CYC
) (
	input  wire logic   mclk_i,
	input  wire logic   reset_i,
	mmp_mgmt_if.engine  cmd,
	output logic        mdc_o,
	input  wire logic   mdio_i,
	output logic        mdio_o,
	output logic        mdio_oe_o
);
	localparam int TOTAL_S = mmp_pkg::MGMT_IDLE_BITS + mmp_pkg::MGMT_SINGLE_BITS;
	localparam int TOTAL_M = mmp_pkg::MGMT_IDLE_BITS + mmp_pkg::MGMT_MULTI_BITS;

	mmp_pkg::mmp_mg_state_type state_q;
	logic [15:0] mem_q [mmp_pkg::MGMT_WORDS];
	logic [7:0]  half_q;
	logic [7:0]  bit_q;
	logic [7:0]  last_q;
	logic [15:0] hdr_q;
	logic        rd_q;
	logic        mdc_q;
	logic        mdio_s1_q;
	logic        mdio_s2_q;
	logic        half_end;

	// frame bit to drive at index b
	function automatic logic frame_bit(input logic [7:0] b, input logic [15:0] hdr);
		logic [7:0] f;
		logic [7:0] d;
		f = b - 8'(mmp_pkg::MGMT_IDLE_BITS);
		d = f - 8'(mmp_pkg::MGMT_HDR_BITS);
		if (b < 8'(mmp_pkg::MGMT_IDLE_BITS))
			frame_bit = 1'b1;
		else if (f < 8'(mmp_pkg::MGMT_HDR_BITS))
			frame_bit = hdr[4'(15 - f)];
		else
			frame_bit = mem_q[d[7:4]][4'(15 - d[3:0])];
	endfunction : frame_bit

	// true while the line is released for the PHY on reads
	function automatic logic released(input logic [7:0] b, input logic rd);
		released = rd && (b >= 8'(mmp_pkg::MGMT_IDLE_BITS + mmp_pkg::MGMT_ADDR_BITS));
	endfunction : released

	assign half_end = (half_q == 8'(HALF_CYC - 1));
	assign cmd.busy = (state_q == mmp_pkg::MG_RUN);
	assign cmd.rdata = mem_q[cmd.idx];
	assign mdc_o = mdc_q;

	always_ff @(posedge mclk_i) begin
		mdio_s1_q <= mdio_i;
		mdio_s2_q <= mdio_s1_q;
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i || state_q == mmp_pkg::MG_IDLE || half_end)
			half_q <= 8'h00;
		else
			half_q <= half_q + 8'h01;
	end

	// each phase lasts HALF_CYC system clocks
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			state_q   <= mmp_pkg::MG_IDLE;
			mdc_q     <= 1'b0;
			bit_q     <= 8'h00;
			last_q    <= 8'h00;
			hdr_q     <= 16'h0000;
			rd_q      <= 1'b0;
			mdio_o    <= 1'b1;
			mdio_oe_o <= 1'b0;
			cmd.done  <= 1'b0;
		end else begin
			cmd.done <= 1'b0;
			unique case (state_q)
				mmp_pkg::MG_IDLE: begin
					mdc_q     <= 1'b0;
					mdio_oe_o <= 1'b0;
					if (cmd.start) begin
						hdr_q <= {mmp_pkg::MGMT_START, cmd.op, cmd.phy_addr,
							cmd.reg_select_field, 2'b10};
						rd_q  <= (cmd.op == mmp_pkg::MGMT_OP_READ);
						last_q <= (cmd.multi_en &&
							cmd.reg_select_field == mmp_pkg::MGMT_REG_ALL) ?
							8'(TOTAL_M - 1) : 8'(TOTAL_S - 1);
						bit_q     <= 8'h00;
						mdio_o    <= 1'b1;
						mdio_oe_o <= 1'b1;
						state_q   <= mmp_pkg::MG_RUN;
					end
				end
				mmp_pkg::MG_RUN: begin
					if (half_end) begin
						mdc_q <= ~mdc_q;
						if (mdc_q) begin
							// falling edge: move to next bit
							if (bit_q == last_q) begin
								mdio_oe_o <= 1'b0;
								cmd.done  <= 1'b1;
								state_q   <= mmp_pkg::MG_IDLE;
							end else begin
								bit_q     <= bit_q + 8'h01;
								mdio_o    <= frame_bit(bit_q + 8'h01, hdr_q);
								mdio_oe_o <= ~released(bit_q + 8'h01, rd_q);
							end
						end
					end
				end
			endcase
		end
	end

	// data words, MSB first; read bits captured at rising edge
	always_ff @(posedge mclk_i) begin
		if (state_q == mmp_pkg::MG_IDLE && cmd.wr_en)
			mem_q[cmd.idx] <= cmd.wdata;
		else if (state_q == mmp_pkg::MG_RUN && half_end && !mdc_q && rd_q &&
			bit_q >= 8'(mmp_pkg::MGMT_IDLE_BITS + mmp_pkg::MGMT_HDR_BITS)) begin
			mem_q[4'((bit_q - 8'(mmp_pkg::MGMT_IDLE_BITS + mmp_pkg::MGMT_HDR_BITS)) >> 4)]
				[4'(15 - bit_q[3:0])] <= mdio_s2_q;
		end
	end
endmodule : mmp_mgmt_serial
`default_nettype wire

// ### design/mmp_mii_port.sv
// Purpose: MAC side of the nibble media independent interface with APB registers
// Assumes: PHY clocks and status pins are asynchronous to mclk_i
// Notes: PHY clocks are oversampled; outputs follow detected rising edges
`timescale 1ns/1ps
`default_nettype none
module mmp_mii_port (
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// transmit
	input  wire logic        tx_nibble_clock_i,
	output logic             tx_enable_out_o,
	output logic [3:0]       txd_o,
	// receive, carrier sense and collision
	input  wire logic        rx_nibble_clock_i,
	input  wire logic        rx_dv_i,
	input  wire logic        rx_er_i,
	input  wire logic [3:0]  rxd_i,
	input  wire logic        carrier_sense_in_i,
	input  wire logic        collision_in_i,
	// management serial
	output logic             mdc_o,
	input  wire logic        mdio_i,
	output logic             mdio_o,
	output logic             mdio_oe_o,
	// configuration
	output logic             external_phy_select_o,
	output logic             media_if_disable_o
);
	mmp_mgmt_if mg ();

	logic        external_phy_select_bit_q;
	logic        media_dis_q;
	logic        full_dup_q;
	logic [8:0]  tx_hold_q;
	logic        tx_hold_v_q;
	logic [7:0]  tx_cur_q;
	logic        tx_last_q;
	logic [3:0]  pre_cnt_q;
	logic        tx_under_q;
	logic        coll_q;
	logic [7:0]  rx_byte_q;
	logic        rx_valid_q;
	logic        rx_done_q;
	logic        rx_bad_q;
	logic        rx_over_q;
	logic [3:0]  rx_prev_q;
	logic [3:0]  rx_lo_q;
	logic        rx_half_q;
	logic        rx_err_q;
	logic [3:0]  mg_idx_q;
	logic [31:0] rd_mux;
	logic [31:0] status;
	logic        setup;
	logic        access;
	logic        wr_acc;
	logic        rd_acc;
	logic        mapped;
	logic        tx_take;
	logic        tx_edge;
	logic        rx_edge;
	logic        carrier;
	logic        collision;
	logic        rx_pop;
	logic        rx_push;
	logic        rx_end;
	logic        rx_end_bad;
	logic        tx_coll;
	logic        tx_under_ev;
	logic [2:0]  txc_q;
	logic [2:0]  rxc_q;
	logic [1:0]  crs_q;
	logic [1:0]  col_q;
	logic [1:0]  dv_q;
	logic [1:0]  er_q;
	logic [3:0]  rxd1_q;
	logic [3:0]  rxd2_q;
	mmp_pkg::mmp_tx_state_type tx_state_q;
	mmp_pkg::mmp_rx_state_type rx_state_q;

	// two-stage synchronisers; stage 0 feeds only stage 1
	always_ff @(posedge mclk_i) begin
		txc_q  <= {txc_q[1:0], tx_nibble_clock_i};
		rxc_q  <= {rxc_q[1:0], rx_nibble_clock_i};
		crs_q  <= {crs_q[0], carrier_sense_in_i};
		col_q  <= {col_q[0], collision_in_i};
		dv_q   <= {dv_q[0], rx_dv_i};
		er_q   <= {er_q[0], rx_er_i};
		rxd1_q <= rxd_i;
		rxd2_q <= rxd1_q;
	end

	assign tx_edge   = txc_q[1] && !txc_q[2];
	assign rx_edge   = rxc_q[1] && !rxc_q[2];
	assign carrier   = crs_q[1];
	assign collision = col_q[1];

	// APB decode, zero wait states
	assign setup    = psel_i && !penable_i;
	assign access   = psel_i && penable_i;
	assign pready_o = 1'b1;
	assign mapped   = (paddr_i == mmp_pkg::ADDR_CONFIG) || (paddr_i == mmp_pkg::ADDR_STATUS)
		|| (paddr_i == mmp_pkg::ADDR_TX_DATA) || (paddr_i == mmp_pkg::ADDR_RX_DATA)
		|| (paddr_i == mmp_pkg::ADDR_MGMT_CMD) || (paddr_i == mmp_pkg::ADDR_MGMT_DATA)
		|| (paddr_i == mmp_pkg::ADDR_MGMT_IDX);
	assign pslverr_o = access && !mapped;
	assign wr_acc    = access && pwrite_i && mapped;
	assign rd_acc    = access && !pwrite_i && mapped;
	assign rx_pop    = rd_acc && (paddr_i == mmp_pkg::ADDR_RX_DATA);

	always_comb begin
		status = 32'h0000_0000;
		status[mmp_pkg::ST_TX_BUSY]   = (tx_state_q != mmp_pkg::TX_IDLE);
		status[mmp_pkg::ST_TX_EMPTY]  = !tx_hold_v_q;
		status[mmp_pkg::ST_RX_VALID]  = rx_valid_q;
		status[mmp_pkg::ST_RX_DONE]   = rx_done_q;
		status[mmp_pkg::ST_RX_BAD]    = rx_bad_q;
		status[mmp_pkg::ST_COLL]      = coll_q;
		status[mmp_pkg::ST_CARRIER]   = carrier;
		status[mmp_pkg::ST_MGMT_BUSY] = mg.busy;
		status[mmp_pkg::ST_RX_OVER]   = rx_over_q;
		status[mmp_pkg::ST_TX_UNDER]  = tx_under_q;
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (paddr_i)
			mmp_pkg::ADDR_CONFIG: begin
				rd_mux[mmp_pkg::CFG_EXTERNAL_PHY_SELECT_BIT_BIT]   = external_phy_select_bit_q;
				rd_mux[mmp_pkg::CFG_MEDIA_DIS_BIT] = media_dis_q;
				rd_mux[mmp_pkg::CFG_FULL_DUP_BIT]  = full_dup_q;
			end
			mmp_pkg::ADDR_STATUS:    rd_mux = status;
			mmp_pkg::ADDR_TX_DATA:   rd_mux = {23'h000000, tx_hold_q};
			mmp_pkg::ADDR_RX_DATA:   rd_mux = {23'h000000, rx_valid_q, rx_byte_q};
			mmp_pkg::ADDR_MGMT_CMD:  rd_mux = {24'h000000, 7'h00, mg.busy};
			mmp_pkg::ADDR_MGMT_DATA: rd_mux = {16'h0000, mg.rdata};
			mmp_pkg::ADDR_MGMT_IDX:  rd_mux = {28'h0000000, mg_idx_q};
			default:                 rd_mux = 32'h0000_0000;
		endcase
	end

	// read data captured in the setup cycle
	always_ff @(posedge mclk_i) begin
		if (reset_i)
			prdata_o <= 32'h0000_0000;
		else if (setup)
			prdata_o <= rd_mux;
	end

	// configuration; internal PHY isolated from reset
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			external_phy_select_bit_q   <= mmp_pkg::CFG_EXTERNAL_PHY_SELECT_BIT_RST;
			media_dis_q <= mmp_pkg::CFG_MEDIA_DIS_RST;
			full_dup_q  <= mmp_pkg::CFG_FULL_DUP_RST;
		end else if (wr_acc && paddr_i == mmp_pkg::ADDR_CONFIG) begin
			external_phy_select_bit_q   <= pwdata_i[mmp_pkg::CFG_EXTERNAL_PHY_SELECT_BIT_BIT];
			media_dis_q <= pwdata_i[mmp_pkg::CFG_MEDIA_DIS_BIT];
			full_dup_q  <= pwdata_i[mmp_pkg::CFG_FULL_DUP_BIT];
		end
	end
	assign external_phy_select_o = external_phy_select_bit_q;
	assign media_if_disable_o    = media_dis_q;

	// management command port
	always_ff @(posedge mclk_i) begin
		if (reset_i)
			mg_idx_q <= 4'h0;
		else if (wr_acc && paddr_i == mmp_pkg::ADDR_MGMT_IDX)
			mg_idx_q <= pwdata_i[3:0];
	end
	assign mg.start = wr_acc && paddr_i == mmp_pkg::ADDR_MGMT_CMD &&
		pwdata_i[mmp_pkg::CMD_GO_BIT] && !mg.busy;
	assign mg.op               = pwdata_i[mmp_pkg::CMD_OP_LSB +: 2];
	assign mg.phy_addr         = pwdata_i[mmp_pkg::CMD_PHY_LSB +: 5];
	assign mg.reg_select_field = pwdata_i[mmp_pkg::CMD_REG_LSB +: 5];
	assign mg.multi_en         = pwdata_i[mmp_pkg::CMD_MULTI_BIT];
	assign mg.idx              = mg_idx_q;
	assign mg.wr_en            = wr_acc && paddr_i == mmp_pkg::ADDR_MGMT_DATA;
	assign mg.wdata            = pwdata_i[15:0];

	mmp_mgmt_serial u_mgmt (
		.mclk_i    (mclk_i),
		.reset_i   (reset_i),
		.cmd       (mg),
		.mdc_o     (mdc_o),
		.mdio_i    (mdio_i),
		.mdio_o    (mdio_o),
		.mdio_oe_o (mdio_oe_o)
	);

	// transmit holding byte, one deep
	assign tx_take = tx_edge && (tx_state_q == mmp_pkg::TX_LO) && tx_hold_v_q && !collision;
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			tx_hold_q   <= 9'h000;
			tx_hold_v_q <= 1'b0;
		end else if (wr_acc && paddr_i == mmp_pkg::ADDR_TX_DATA && !tx_hold_v_q) begin
			tx_hold_q   <= pwdata_i[8:0];
			tx_hold_v_q <= 1'b1;
		end else if (tx_take || (tx_coll && tx_hold_v_q)) begin
			tx_hold_v_q <= 1'b0;
		end
	end

	assign tx_coll     = tx_edge && tx_enable_out_o && collision;
	assign tx_under_ev = tx_edge && (tx_state_q == mmp_pkg::TX_LO) && !tx_hold_v_q &&
		!collision;

	// transmit nibble sequencer
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			tx_state_q      <= mmp_pkg::TX_IDLE;
			tx_enable_out_o <= 1'b0;
			txd_o           <= 4'h0;
			pre_cnt_q       <= 4'h0;
			tx_cur_q        <= 8'h00;
			tx_last_q       <= 1'b0;
		end else if (tx_edge) begin
			if (tx_coll) begin
				tx_enable_out_o <= 1'b0;
				txd_o           <= 4'h0;
				tx_state_q      <= mmp_pkg::TX_IDLE;
			end else begin
				unique case (tx_state_q)
					mmp_pkg::TX_IDLE: begin
						tx_enable_out_o <= 1'b0;
						txd_o           <= 4'h0;
						if (tx_hold_v_q && (full_dup_q || !carrier)) begin
							tx_enable_out_o <= 1'b1;
							txd_o           <= mmp_pkg::NIB_PREAMBLE;
							pre_cnt_q       <= 4'h1;
							tx_state_q      <= mmp_pkg::TX_PRE;
						end
					end
					mmp_pkg::TX_PRE: begin
						pre_cnt_q <= pre_cnt_q + 4'h1;
						if (pre_cnt_q == mmp_pkg::PRE_NIBBLES) begin
							txd_o      <= mmp_pkg::NIB_SFD;
							tx_state_q <= mmp_pkg::TX_LO;
						end else begin
							txd_o <= mmp_pkg::NIB_PREAMBLE;
						end
					end
					mmp_pkg::TX_LO: begin
						if (tx_hold_v_q) begin
							txd_o      <= tx_hold_q[3:0];
							tx_cur_q   <= tx_hold_q[7:0];
							tx_last_q  <= tx_hold_q[mmp_pkg::DATA_LAST_BIT];
							tx_state_q <= mmp_pkg::TX_HI;
						end else begin
							tx_enable_out_o <= 1'b0;
							txd_o           <= 4'h0;
							tx_state_q      <= mmp_pkg::TX_IDLE;
						end
					end
					mmp_pkg::TX_HI: begin
						txd_o <= tx_cur_q[7:4];
						tx_state_q <= tx_last_q ? mmp_pkg::TX_IDLE : mmp_pkg::TX_LO;
					end
				endcase
			end
		end
	end

	// receive framing
	assign rx_push = rx_edge && dv_q[1] && (rx_state_q == mmp_pkg::RX_DATA) && rx_half_q;
	assign rx_end  = rx_edge && !dv_q[1] && (rx_state_q != mmp_pkg::RX_IDLE);
	assign rx_end_bad = rx_err_q || rx_half_q || (rx_state_q != mmp_pkg::RX_DATA);

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			rx_state_q <= mmp_pkg::RX_IDLE;
			rx_prev_q  <= 4'h0;
			rx_lo_q    <= 4'h0;
			rx_half_q  <= 1'b0;
			rx_err_q   <= 1'b0;
		end else if (rx_edge) begin
			if (!dv_q[1]) begin
				rx_state_q <= mmp_pkg::RX_IDLE;
				rx_half_q  <= 1'b0;
				rx_err_q   <= 1'b0;
			end else begin
				rx_err_q  <= rx_err_q || er_q[1];
				rx_prev_q <= rxd2_q;
				unique case (rx_state_q)
					mmp_pkg::RX_IDLE: rx_state_q <= mmp_pkg::RX_HUNT;
					mmp_pkg::RX_HUNT: begin
						if (rx_prev_q == mmp_pkg::NIB_PREAMBLE && rxd2_q == mmp_pkg::NIB_SFD)
							rx_state_q <= mmp_pkg::RX_DATA;
					end
					mmp_pkg::RX_DATA: begin
						rx_half_q <= !rx_half_q;
						if (!rx_half_q)
							rx_lo_q <= rxd2_q;
					end
				endcase
			end
		end
	end

	// received byte register; hardware set wins over software pop
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			rx_byte_q  <= 8'h00;
			rx_valid_q <= 1'b0;
		end else if (rx_push && (!rx_valid_q || rx_pop)) begin
			rx_byte_q  <= {rxd2_q, rx_lo_q};
			rx_valid_q <= 1'b1;
		end else if (rx_pop) begin
			rx_valid_q <= 1'b0;
		end
	end

	// sticky status, write one to clear, set wins
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			rx_done_q  <= 1'b0;
			rx_bad_q   <= 1'b0;
			rx_over_q  <= 1'b0;
			coll_q     <= 1'b0;
			tx_under_q <= 1'b0;
		end else begin
			if (rx_end)
				rx_done_q <= 1'b1;
			else if (wr_acc && paddr_i == mmp_pkg::ADDR_STATUS && pwdata_i[mmp_pkg::ST_RX_DONE])
				rx_done_q <= 1'b0;
			if (rx_end && rx_end_bad)
				rx_bad_q <= 1'b1;
			else if (wr_acc && paddr_i == mmp_pkg::ADDR_STATUS && pwdata_i[mmp_pkg::ST_RX_BAD])
				rx_bad_q <= 1'b0;
			if (rx_push && rx_valid_q && !rx_pop)
				rx_over_q <= 1'b1;
			else if (wr_acc && paddr_i == mmp_pkg::ADDR_STATUS && pwdata_i[mmp_pkg::ST_RX_OVER])
				rx_over_q <= 1'b0;
			if (tx_coll)
				coll_q <= 1'b1;
			else if (wr_acc && paddr_i == mmp_pkg::ADDR_STATUS && pwdata_i[mmp_pkg::ST_COLL])
				coll_q <= 1'b0;
			if (tx_under_ev)
				tx_under_q <= 1'b1;
			else if (wr_acc && paddr_i == mmp_pkg::ADDR_STATUS && pwdata_i[mmp_pkg::ST_TX_UNDER])
				tx_under_q <= 1'b0;
		end
	end
endmodule : mmp_mii_port
`default_nettype wire

// ### testbench/mmp_port_asserts.sv
// Purpose: port checks for mmp_mii_port
// Assumes: bound to the top module
// Notes: none
`timescale 1ns/1ps
`default_nettype none
module mmp_port_asserts (
	input wire logic       mclk_i,
	input wire logic       reset_i,
	input wire logic       tx_nibble_clock_i,
	input wire logic       collision_in_i,
	input wire logic       tx_enable_out_o,
	input wire logic [3:0] txd_o,
	input wire logic       mdc_o,
	input wire logic       mdio_o,
	input wire logic       mdio_oe_o,
	input wire logic       external_phy_select_o,
	input wire logic       media_if_disable_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	logic       mdc_q;
	logic [7:0] half_q;
	always_ff @(posedge mclk_i) begin
		mdc_q <= mdc_o;
	end
	// cycles since last management clock change
	always_ff @(posedge mclk_i) begin
		if (reset_i || mdc_o != mdc_q) half_q <= 8'h01;
		else if (half_q != 8'hFF) half_q <= half_q + 8'h01;
	end
	cfg_reset_a: assert property (disable iff (1'b0) $fell(reset_i) |->
		!external_phy_select_o && media_if_disable_o) else $error("config reset wrong");
	mdc_half_a: assert property (mdc_o != mdc_q |-> half_q >= 8'h28)
		else $error("mdc phase short");
	tx_start_a: assert property ($rose(tx_enable_out_o) |-> txd_o == 4'h5)
		else $error("frame start nibble");
	tx_edge_a: assert property ($changed(txd_o) || $changed(tx_enable_out_o) |->
		tx_nibble_clock_i) else $error("tx change off edge");
	tx_end_a: assert property ($fell(tx_enable_out_o) |-> txd_o == 4'h0)
		else $error("tx end data");
	col_stop_a: assert property ($rose(collision_in_i) && tx_enable_out_o |->
		##[1:48] !tx_enable_out_o) else $error("collision ignored");
	idle_ones_a: assert property ($rose(mdio_oe_o) |-> mdio_o)
		else $error("access not led by ones");
	mdio_hold_a: assert property ($changed(mdio_o) |-> !mdc_o)
		else $error("mdio moved with mdc high");
endmodule : mmp_port_asserts
bind mmp_mii_port mmp_port_asserts chk_u (.mclk_i, .reset_i, .tx_nibble_clock_i,
	.collision_in_i, .tx_enable_out_o, .txd_o, .mdc_o, .mdio_o, .mdio_oe_o,
	.external_phy_select_o, .media_if_disable_o);
`default_nettype wire

// ### testbench/mmp_phy_model.sv
// Purpose: external PHY side of the nibble link
// Assumes: free running nibble clocks, pulled-up management line
// Notes: records the last 64 management bits
`timescale 1ns/1ps
`default_nettype none
module mmp_phy_model (
	output logic        tx_clk_o,
	output logic        rx_clk_o,
	output logic        rx_dv_o,
	output logic        rx_er_o,
	output logic [3:0]  rxd_o,
	output logic        crs_o,
	input wire logic    tx_en_i,
	input wire logic    mdc_i,
	input wire logic    mdio_i,
	output logic [63:0] mgmt_bits_o
);
	initial begin
		tx_clk_o = 1'b0;
		forever #32 tx_clk_o = ~tx_clk_o;
	end
	initial begin
		rx_clk_o = 1'b0;
		rx_dv_o = 1'b0;
		rx_er_o = 1'b0;
		rxd_o = 4'hA;
		#11;
		forever #32 rx_clk_o = ~rx_clk_o;
	end
	assign crs_o = rx_dv_o | tx_en_i;
	always @(posedge mdc_i) mgmt_bits_o <= {mgmt_bits_o[62:0], mdio_i};
	task automatic send(input logic [3:0] n[$], input int er_at);
		for (int i = 0; i < n.size(); i++) begin
			@(negedge rx_clk_o);
			rx_dv_o <= 1'b1;
			rxd_o <= n[i];
			rx_er_o <= (i == er_at);
		end
		@(negedge rx_clk_o);
		rx_dv_o <= 1'b0;
		rx_er_o <= 1'b0;
		rxd_o <= ~n[n.size() - 1];
	endtask : send
endmodule : mmp_phy_model
`default_nettype wire

// ### testbench/tb_top.sv
// Purpose: self-checking bench for mmp_mii_port
// Assumes: APB master, PHY model on the nibble link
// Notes: management line pulled up
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        mclk_i = 1'b0, reset_i = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic        col = 1'b0, bus_err, pready, pslverr, txc, rxc, dv, er, crs, txen;
	logic        mdc, mdo, moe, ext, dis;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0]  rxd, txd, txq[$];
	logic [63:0] mbits;
	int          n_fail = 0, tests_run = 0;
	wire logic   mdio_w = moe ? mdo : 1'b1;
	always #2 mclk_i = ~mclk_i;
	always @(negedge txc) if (txen === 1'b1) txq.push_back(txd);
	mmp_mii_port dut_u (.mclk_i, .reset_i, .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .tx_nibble_clock_i(txc), .tx_enable_out_o(txen), .txd_o(txd),
		.rx_nibble_clock_i(rxc), .rx_dv_i(dv), .rx_er_i(er), .rxd_i(rxd),
		.carrier_sense_in_i(crs), .collision_in_i(col), .mdc_o(mdc), .mdio_i(mdio_w),
		.mdio_o(mdo), .mdio_oe_o(moe), .external_phy_select_o(ext), .media_if_disable_o(dis));
	mmp_phy_model phy_u (.tx_clk_o(txc), .rx_clk_o(rxc), .rx_dv_o(dv), .rx_er_o(er),
		.rxd_o(rxd), .crs_o(crs), .tx_en_i(txen), .mdc_i(mdc), .mdio_i(mdio_w),
		.mgmt_bits_o(mbits));
	task automatic report_and_stop;
		$display("checks %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic tmo(input logic stuck);
		if (stuck !== 1'b0) begin
			n_fail++;
			report_and_stop;
		end
	endtask : tmo
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge mclk_i);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_i);
		pen <= 1'b1;
		k = 0;
		do begin
			@(posedge mclk_i);
			k++;
		end while (pready !== 1'b1 && k < 50);
		tmo(pready !== 1'b1);
		rd = prdata;
		bus_err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task automatic wait_for(ref logic s, input logic v);
		int k;
		k = 0;
		while (s !== v && k < 3000) begin
			@(posedge mclk_i);
			k++;
		end
		chk(32'(s), 32'(v));
		if (s !== v) report_and_stop;
	endtask : wait_for
	task automatic t_regs;
		apb(1'b0, mmp_pkg::ADDR_CONFIG, 32'h0);
		chk(rd, 32'h2);
		apb(1'b0, 8'hFC, 32'h0);
		chk({rd[30:0], bus_err}, 32'h1);
		apb(1'b1, mmp_pkg::ADDR_CONFIG, 32'h0);
		@(posedge mclk_i);
		chk(32'({ext, dis}), 32'h0);
	endtask : t_regs
	task automatic t_tx;
		txq = {};
		apb(1'b1, mmp_pkg::ADDR_TX_DATA, 32'h1A7);
		wait_for(txen, 1'b1);
		wait_for(txen, 1'b0);
		chk(32'(txq.size()), 32'd18);
		foreach (txq[i]) chk(32'(txq[i]), i < 15 ? 32'h5 : i == 15 ? 32'hD :
			i == 16 ? 32'h7 : 32'hA);
	endtask : t_tx
	task automatic t_col;
		apb(1'b1, mmp_pkg::ADDR_TX_DATA, 32'h055);
		wait_for(txen, 1'b1);
		repeat (40) @(posedge mclk_i);
		col <= 1'b1;
		wait_for(txen, 1'b0);
		col <= 1'b0;
		apb(1'b0, mmp_pkg::ADDR_STATUS, 32'h0);
		chk(rd & 32'h20, 32'h20);
		apb(1'b1, mmp_pkg::ADDR_STATUS, 32'h20);
	endtask : t_col
	task automatic t_rx(input int er_at, input logic [31:0] st);
		int k;
		logic [3:0] n[$];
		n = {4'h9, 4'h5, 4'h5, 4'h5, 4'hD, 4'h3, 4'hC};
		phy_u.send(n, er_at);
		k = 0;
		do begin
			apb(1'b0, mmp_pkg::ADDR_STATUS, 32'h0);
			k++;
		end while (rd[3] !== 1'b1 && k < 30);
		tmo(rd[3] !== 1'b1);
		chk(rd & 32'h18, st);
		apb(1'b0, mmp_pkg::ADDR_RX_DATA, 32'h0);
		chk(rd, 32'h1C3);
		apb(1'b1, mmp_pkg::ADDR_STATUS, 32'h18);
	endtask : t_rx
	task automatic t_mgmt(input logic [1:0] op, input logic [15:0] d);
		int k;
		apb(1'b1, mmp_pkg::ADDR_MGMT_DATA, 32'hBEEF);
		apb(1'b1, mmp_pkg::ADDR_MGMT_CMD, 32'h80000280 | 32'(op));
		k = 0;
		do begin
			apb(1'b0, mmp_pkg::ADDR_STATUS, 32'h0);
			k++;
		end while (rd[7] !== 1'b0 && k < 4000);
		tmo(rd[7] !== 1'b0);
		chk(mbits[63:32], 32'hFFFFFFFF);
		chk(32'({mbits[31:18], mbits[15:0]}), 32'({2'b01, op, 10'h005, d}));
		apb(1'b0, mmp_pkg::ADDR_MGMT_DATA, 32'h0);
		chk(rd, 32'(d));
	endtask : t_mgmt
	initial begin
		#400000;
		n_fail++;
		report_and_stop;
	end
	initial begin
		repeat (16) @(posedge mclk_i);
		reset_i <= 1'b0;
		t_regs;
		t_tx;
		t_col;
		t_rx(-1, 32'h08);
		t_rx(5, 32'h18);
		t_mgmt(mmp_pkg::MGMT_OP_WRITE, 16'hBEEF);
		t_mgmt(mmp_pkg::MGMT_OP_READ, 16'hFFFF);
		report_and_stop;
	end
endmodule : tb_top
`default_nettype wire
